// [hw/cpusb_pkg.sv]
// Shared constants for the processor sideband block.
package cpusb_pkg;
  localparam int unsigned SYNC_STAGES   = 2;
  localparam logic        LAPIC_EN_RST  = 1'b1;
  localparam logic [1:0]  LINT_ZERO     = 2'h0;
  localparam int unsigned LINT_IRQ_BIT  = 0;
  localparam int unsigned LINT_NMI_BIT  = 1;
  typedef enum logic [2:0] {
    CPUSB_LK_IDLE = 3'h1,
    CPUSB_LK_HOLD = 3'h2,
    CPUSB_LK_WAIT = 3'h4
  } cpusb_lock_t;
endpackage : cpusb_pkg

// [hw/cpusb_sync.sv]
// Two-flop synchroniser for asynchronous inputs.
module cpusb_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_sys,  // System clock.
  input  wire logic         rst_n,    // Async reset, active low.
  input  wire logic [W-1:0] async_in, // Asynchronous level.
  output logic      [W-1:0] sync_out  // Synchronised level.
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb
  begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule : cpusb_sync

// [hw/cpusb_top.sv]
// Processor sideband: error reporting, init, local interrupts, snoop stall and bus lock.
// Behaviour
// RULE_01: Outside stop-clock, unmasked floating-point error asserts error-or-break output.
// RULE_02: During stop-clock, error-or-break output signals a pending break event.
// RULE_03: Break indication stays asserted until stop-clock deasserts.
// RULE_04: Snoop stall is requested by asserting snoop-hit and hit-modified together.
// RULE_05: Internal-error output asserts on internal error and holds until reset.
// RULE_06: Internal error also issues a halt transaction request on the bus.
// RULE_07: Ignore-numeric-error asserted lets floating-point work continue past pending errors.
// RULE_08: Otherwise a pending error raises an exception on non-control FP instruction.
// RULE_09: Ignore-numeric-error is disregarded while the native numeric error bit is set.
// RULE_10: System presents ignore-numeric-error valid with target-ready of the I/O write.
// RULE_11: Soft-init resets integer registers, keeps caches, restarts at reset vector.
// RULE_12: Snoop requests keep being serviced during soft-init.
// RULE_13: Soft-init is asynchronous and is synchronised before use.
// RULE_14: Soft-init active at reset release requests built-in self-test.
// RULE_15: Controller disabled: input 0 is maskable request, input 1 non-maskable.
// RULE_16: Local interrupt inputs are synchronised before use.
// RULE_17: Local interrupt controller is enabled after reset.
// RULE_18: Bus-lock output held from first transaction start to last transaction end.
// RULE_19: Priority agent waits for bus-lock deasserted before taking the bus.
// RULE_20: Every asynchronous input passes a two-stage synchroniser first.
module cpusb_top (
  input  wire logic       clk_sys,                  // Bus clock, 20 MHz.
  input  wire logic       rst_n,                    // Async reset, active low.
  input  wire logic       stop_clock_in_n,          // Stop-clock request, active low, synchronous.
  input  wire logic       fp_error,                 // Unmasked floating-point error detected, level.
  input  wire logic       break_event,              // Break event pending, pulse.
  input  wire logic       internal_fault,           // Internal error detected, pulse.
  input  wire logic       ignore_numeric_error_in_n, // Async ignore-numeric-error pin, active low.
  input  wire logic       native_numeric_error_bit, // Native error bit of control register zero.
  input  wire logic       fp_noncontrol_issue,      // Non-control FP instruction issued, pulse.
  input  wire logic       soft_init_in_n,           // Async soft-init pin, active low.
  input  wire logic [1:0] local_interrupt_in,       // Async local interrupt pins.
  input  wire logic       lapic_disable,            // Software clears the local controller.
  input  wire logic       snoop_stall_req,          // Core wants a snoop stall.
  input  wire logic       lock_seq_start,           // First transaction of locked sequence begins.
  input  wire logic       lock_seq_end,             // Last transaction of locked sequence ends.
  output logic            error_or_break_out_n,     // Error-or-break pin, active low, registered.
  output logic            internal_error_out_n,     // Internal-error pin, active low, registered.
  output logic            halt_transaction,         // Halt transaction request, one-cycle pulse.
  output logic            fp_exception,             // FP exception raised, one-cycle pulse.
  output logic            int_reg_reset,            // Integer register reset, one-cycle pulse.
  output logic            fetch_reset_vector,       // Restart at reset vector, one-cycle pulse.
  output logic            snoop_enable,             // Snoop servicing enabled, level.
  output logic            bist_request,             // Self-test requested at reset release.
  output logic            snoop_hit_n,              // Snoop-hit pin, active low.
  output logic            snoop_hit_oe,             // Snoop-hit output enable.
  output logic            hit_modified_n,           // Hit-modified pin, active low.
  output logic            hit_modified_oe,          // Hit-modified output enable.
  output logic            maskable_interrupt_request, // Maskable interrupt level.
  output logic            nmi_request,              // Non-maskable interrupt, one-cycle pulse.
  output logic [1:0]      lapic_lint,               // Local interrupt levels to the controller.
  output logic            bus_lock_n,               // Bus-lock pin, active low.
  output logic            bus_lock_oe               // Bus-lock output enable.
);

  logic [3:0] sync_out;

  // One shared synchroniser bank for all asynchronous pins.
  // Active-low pins are inverted ahead of it, so its cleared flops read as idle after reset.
  cpusb_sync #(
    .W (4)
  ) u_sync (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .async_in ({local_interrupt_in, ~soft_init_in_n, ~ignore_numeric_error_in_n}),
    .sync_out (sync_out)
  ); // RULE_13 RULE_16 RULE_20

  logic ign_s;
  logic init_s;
  logic [1:0] lint_s;
  logic stop_req;
  assign ign_s    = sync_out[0];
  assign init_s   = sync_out[1];
  assign lint_s   = sync_out[3:2];
  assign stop_req = ~stop_clock_in_n;

  // Error reporting state.
  logic eob_q;
  logic eob_d;
  logic brk_q;
  logic brk_d;
  logic fault_q;
  logic fault_d;
  logic halt_q;
  logic halt_d;
  logic fpx_q;
  logic fpx_d;
  logic fp_pend_q;
  logic fp_pend_d;

  always_comb
  begin
    // A pending break is held until stop-clock leaves, clear wins over set.
    brk_d   = (brk_q & stop_req) | (stop_req & break_event); // RULE_02 RULE_03
    eob_d   = stop_req ? brk_d : fp_error; // RULE_01
    fault_d = fault_q | internal_fault; // RULE_05
    halt_d  = internal_fault & ~fault_q; // RULE_06
    fp_pend_d = fp_pend_q | fp_error;
    fpx_d = 1'b0;
    if (fp_noncontrol_issue && fp_pend_q)
    begin
      // Native reporting ignores the pin entirely.
      if (native_numeric_error_bit || !ign_s) // RULE_09
      begin
        fpx_d     = 1'b1; // RULE_08
        fp_pend_d = fp_error;
      end
      // Otherwise execution continues with the error left pending. // RULE_07
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      eob_q     <= 1'b0;
      brk_q     <= 1'b0;
      fault_q   <= 1'b0;
      halt_q    <= 1'b0;
      fpx_q     <= 1'b0;
      fp_pend_q <= 1'b0;
    end
    else
    begin
      eob_q     <= eob_d;
      brk_q     <= brk_d;
      fault_q   <= fault_d;
      halt_q    <= halt_d;
      fpx_q     <= fpx_d;
      fp_pend_q <= fp_pend_d;
    end
  end

  assign error_or_break_out_n = ~eob_q;
  assign internal_error_out_n = ~fault_q;
  assign halt_transaction     = halt_q;
  assign fp_exception         = fpx_q;

  // Soft-init and self-test strap.
  logic init_prev_q;
  logic init_prev_d;
  logic irst_q;
  logic irst_d;
  logic [1:0] rel_q;
  logic [1:0] rel_d;
  logic settled;
  logic bist_q;
  logic bist_d;

  always_comb
  begin
    // The synchroniser shows the pin only after SYNC_STAGES edges past release.
    settled     = (rel_q > 2'(cpusb_pkg::SYNC_STAGES));
    rel_d       = settled ? rel_q : rel_q + 2'h1;
    init_prev_d = init_s;
    irst_d      = init_s & ~init_prev_q & settled; // RULE_11
    // A strap held across release asks for self-test; it never counts as a soft-init edge.
    bist_d      = (rel_q == 2'(cpusb_pkg::SYNC_STAGES)) ? init_s : bist_q; // RULE_14
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      init_prev_q <= 1'b0;
      irst_q      <= 1'b0;
      rel_q       <= 2'h0;
      bist_q      <= 1'b0;
    end
    else
    begin
      init_prev_q <= init_prev_d;
      irst_q      <= irst_d;
      rel_q       <= rel_d;
      bist_q      <= bist_d;
    end
  end

  assign int_reg_reset      = irst_q;
  assign fetch_reset_vector = irst_q;
  assign snoop_enable       = 1'b1; // RULE_12
  assign bist_request       = bist_q;

  // Snoop stall drives both result pins together.
  logic stall_q;
  logic stall_d;
  always_comb
  begin
    stall_d = snoop_stall_req; // RULE_04
  end

  // Local interrupts.
  logic lapic_en_q;
  logic lapic_en_d;
  logic mreq_q;
  logic mreq_d;
  logic nmi_q;
  logic nmi_d;
  logic nmi_prev_q;
  logic nmi_prev_d;
  logic [1:0] lint_q;
  logic [1:0] lint_d;

  always_comb
  begin
    lapic_en_d = ~lapic_disable; // RULE_17
    nmi_prev_d = lint_s[cpusb_pkg::LINT_NMI_BIT];
    mreq_d     = 1'b0;
    nmi_d      = 1'b0;
    lint_d     = cpusb_pkg::LINT_ZERO;
    if (lapic_en_q)
    begin
      lint_d = lint_s;
    end
    else
    begin
      mreq_d = lint_s[cpusb_pkg::LINT_IRQ_BIT]; // RULE_15
      nmi_d  = lint_s[cpusb_pkg::LINT_NMI_BIT] & ~nmi_prev_q; // RULE_15
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stall_q    <= 1'b0;
      lapic_en_q <= cpusb_pkg::LAPIC_EN_RST;
      mreq_q     <= 1'b0;
      nmi_q      <= 1'b0;
      nmi_prev_q <= 1'b0;
      lint_q     <= cpusb_pkg::LINT_ZERO;
    end
    else
    begin
      stall_q    <= stall_d;
      lapic_en_q <= lapic_en_d;
      mreq_q     <= mreq_d;
      nmi_q      <= nmi_d;
      nmi_prev_q <= nmi_prev_d;
      lint_q     <= lint_d;
    end
  end

  assign snoop_hit_n     = ~stall_q;
  assign snoop_hit_oe    = stall_q;
  assign hit_modified_n  = ~stall_q;
  assign hit_modified_oe = stall_q;
  assign maskable_interrupt_request = mreq_q;
  assign nmi_request     = nmi_q;
  assign lapic_lint      = lint_q;

  // Bus lock sequencer.
  cpusb_pkg::cpusb_lock_t lk_q;
  cpusb_pkg::cpusb_lock_t lk_d;
  always_comb
  begin
    lk_d = lk_q;
    case (lk_q)
      cpusb_pkg::CPUSB_LK_IDLE:
        if (lock_seq_start)
        begin
          lk_d = cpusb_pkg::CPUSB_LK_HOLD; // RULE_18
        end
      cpusb_pkg::CPUSB_LK_HOLD:
        if (lock_seq_end)
        begin
          lk_d = cpusb_pkg::CPUSB_LK_WAIT;
        end
      cpusb_pkg::CPUSB_LK_WAIT:
        // One idle cycle lets a priority agent see the release.
        lk_d = cpusb_pkg::CPUSB_LK_IDLE; // RULE_19
      default:
        lk_d = cpusb_pkg::CPUSB_LK_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lk_q <= cpusb_pkg::CPUSB_LK_IDLE;
    end
    else
    begin
      lk_q <= lk_d;
    end
  end

  assign bus_lock_n  = (lk_q != cpusb_pkg::CPUSB_LK_HOLD);
  assign bus_lock_oe = (lk_q == cpusb_pkg::CPUSB_LK_HOLD);

  fault_sticky_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_05
    !internal_error_out_n |=> !internal_error_out_n)
    else $error("internal error output dropped before reset");
  fault_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_05
    internal_fault |=> !internal_error_out_n)
    else $error("internal error output not set");
  halt_once_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_06
    (internal_fault && internal_error_out_n) |=> halt_transaction)
    else $error("halt transaction missing");
  fp_report_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_01
    (stop_clock_in_n && fp_error) |=> !error_or_break_out_n)
    else $error("fp error not reported");
  break_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_03
    (!error_or_break_out_n && !stop_clock_in_n && $past(!stop_clock_in_n)) ##1 !stop_clock_in_n
      |-> !error_or_break_out_n)
    else $error("break indication dropped early");
  break_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_02
    (!stop_clock_in_n && break_event) |=> !error_or_break_out_n)
    else $error("break event not reported");
  fpx_ign_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_07
    (ign_s && !native_numeric_error_bit) |=> !fp_exception)
    else $error("exception raised while ignoring errors");
  stall_pair_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_04
    snoop_stall_req |=> (!snoop_hit_n && !hit_modified_n && snoop_hit_oe && hit_modified_oe))
    else $error("snoop stall pins not asserted together");
  lock_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_18
    (!bus_lock_n && !lock_seq_end) |=> !bus_lock_n)
    else $error("bus lock released inside sequence");
  mreq_map_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_15
    (!lapic_en_q && lint_s[0]) |=> maskable_interrupt_request)
    else $error("maskable request not raised");
  ctl_rst_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE_17
    $rose(rst_n) |-> lapic_en_q)
    else $error("local controller not enabled after reset");
endmodule : cpusb_top

// [tb/cpusb_far_model.sv]
// Chipset and priority-agent model that drives the asynchronous sideband pins.
module cpusb_far_model (
  input  wire logic       clk_sys,                   // Bus clock.
  input  wire logic       ign_req,                   // Bench asks for ignore-numeric-error.
  input  wire logic       init_req,                  // Bench asks for soft-init.
  input  wire logic [1:0] lint_req,                  // Bench asks for local interrupt levels.
  input  wire logic       prio_req,                  // Bench asks the priority agent to arbitrate.
  input  wire logic       bus_lock_n,                // Bus-lock pin from the device.
  input  wire logic       bus_lock_oe,               // Bus-lock output enable.
  output logic            ignore_numeric_error_in_n, // Ignore pin, active low.
  output logic            soft_init_in_n,            // Soft-init pin, active low.
  output logic [1:0]      local_interrupt_in,        // Local interrupt pins.
  output logic            target_ready,              // I/O write completion strobe.
  output logic            priority_agent_request,    // Priority bus request.
  output logic            prio_owns_bus              // Priority agent has taken the bus.
);
  timeunit 1ns;
  timeprecision 1ns;
  logic lock_wire;
  // The lock line is pulled up, so a released pin reads as inactive.
  assign lock_wire = bus_lock_oe ? bus_lock_n : 1'b1;
  // Pins move far from the clock edge, as a truly asynchronous source would.
  always @(posedge clk_sys)
  begin
    #17;
    target_ready <= (ignore_numeric_error_in_n === ign_req);
    ignore_numeric_error_in_n <= !ign_req;
    soft_init_in_n <= !init_req;
    local_interrupt_in <= lint_req;
    priority_agent_request <= prio_req;
    prio_owns_bus <= prio_req && (prio_owns_bus || (priority_agent_request && lock_wire));
  end
endmodule : cpusb_far_model

// [tb/tb_top.sv]
// Self-checking bench for the processor sideband block with a cycle model.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_sys = 1'b0;
  logic       rst_n = 1'b0;
  logic       stop_clock_in_n = 1'b1;
  logic       fp_error = 1'b0;
  logic       break_event = 1'b0;
  logic       internal_fault = 1'b0;
  logic       native_numeric_error_bit = 1'b0;
  logic       fp_noncontrol_issue = 1'b0;
  logic       lapic_disable = 1'b0;
  logic       snoop_stall_req = 1'b0;
  logic       lock_seq_start = 1'b0;
  logic       lock_seq_end = 1'b0;
  logic       ign_req = 1'b0;
  logic       init_req = 1'b0;
  logic [1:0] lint_req = 2'h2;
  logic       prio_req = 1'b0;
  logic       ignore_numeric_error_in_n, soft_init_in_n, target_ready, priority_agent_request, prio_owns_bus;
  logic [1:0] local_interrupt_in, lapic_lint;
  logic       error_or_break_out_n, internal_error_out_n, halt_transaction, fp_exception, int_reg_reset;
  logic       fetch_reset_vector, snoop_enable, bist_request, snoop_hit_n, snoop_hit_oe, hit_modified_n;
  logic       hit_modified_oe, maskable_interrupt_request, nmi_request, bus_lock_n, bus_lock_oe;
  int         n_fail = 0;
  int         cmp_count = 0;
  int         m_fault, m_halt, m_lock, m_snp, m_brk, m_eob;
  int         n_irr, n_frv, n_fpx, n_nmi, lat;
  int         age = -99;

  cpusb_top cpusb_top_inst (.clk_sys, .rst_n, .stop_clock_in_n, .fp_error, .break_event, .internal_fault,
    .ignore_numeric_error_in_n, .native_numeric_error_bit, .fp_noncontrol_issue, .soft_init_in_n,
    .local_interrupt_in, .lapic_disable, .snoop_stall_req, .lock_seq_start, .lock_seq_end,
    .error_or_break_out_n, .internal_error_out_n, .halt_transaction, .fp_exception, .int_reg_reset,
    .fetch_reset_vector, .snoop_enable, .bist_request, .snoop_hit_n, .snoop_hit_oe, .hit_modified_n,
    .hit_modified_oe, .maskable_interrupt_request, .nmi_request, .lapic_lint, .bus_lock_n, .bus_lock_oe);
  cpusb_far_model cpusb_far_model_inst (.clk_sys, .ign_req, .init_req, .lint_req, .prio_req, .bus_lock_n,
    .bus_lock_oe, .ignore_numeric_error_in_n, .soft_init_in_n, .local_interrupt_in, .target_ready,
    .priority_agent_request, .prio_owns_bus);

  always #25 clk_sys = ~clk_sys;

  task automatic chk_bit(input logic [1:0] got, input logic [1:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_bit

  task automatic chk_int(input int got, input int exp, input string what);
    cmp_count++;
    if (got != exp)
    begin
      n_fail++;
      $display("[FAIL] %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask : chk_int

  task automatic tally_and_finish();
    if (n_fail == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : step

  task automatic issue();
    fp_noncontrol_issue = 1'b1;
    step(1);
    fp_noncontrol_issue = 1'b0;
    step(2);
  endtask : issue

  always @(negedge soft_init_in_n) age = 0;

  // The model moves on the edge; results are compared once the design's updates have landed.
  always @(posedge clk_sys)
  begin
    age++;
    if (!rst_n)
    begin
      m_fault = 0;
      m_halt = 0;
      m_lock = 0;
      m_snp = 0;
      m_brk = 0;
      m_eob = 0;
    end
    else
    begin
      m_halt = internal_fault;
      m_fault = m_fault | internal_fault;
      m_snp = snoop_stall_req;
      m_lock = (m_lock == 0) ? int'(lock_seq_start) : (m_lock == 1) ? 1 + int'(lock_seq_end) : 0;
      m_brk = !stop_clock_in_n && (m_brk || break_event);
      m_eob = stop_clock_in_n ? fp_error : m_brk;
    end
    #1;
    n_irr += (int_reg_reset === 1'b1);
    n_frv += (fetch_reset_vector === 1'b1);
    n_fpx += (fp_exception === 1'b1);
    n_nmi += (nmi_request === 1'b1);
    if (int_reg_reset === 1'b1) lat = age;
    chk_bit(internal_error_out_n, m_fault == 0, "fault out");
    chk_bit(halt_transaction, m_halt == 1, "halt");
    chk_bit(error_or_break_out_n, m_eob == 0, "eob");
    chk_bit(bus_lock_n, m_lock != 1, "lock");
    chk_bit(bus_lock_oe, m_lock == 1, "lock oe");
    chk_bit({snoop_hit_n, hit_modified_n}, {2{m_snp == 0}}, "hit pair");
    chk_bit({snoop_hit_oe, hit_modified_oe}, {2{m_snp == 1}}, "hit oe");
    chk_bit(snoop_enable, 1'b1, "snoop");
  end

  initial
  begin
    void'($urandom(28348));
    step(2);
    rst_n = 1'b1;
    step(6);
    chk_bit(lapic_lint, 2'h2, "lint on");
    chk_bit({nmi_request, maskable_interrupt_request}, 2'h0, "mreq idle");
    chk_bit(bist_request, 1'b0, "no bist");
    lapic_disable = 1'b1;
    lint_req = 2'h0;
    step(6);
    n_nmi = 0;
    lint_req = 2'h3;
    step(6);
    chk_bit(lapic_lint, 2'h0, "lint off");
    chk_bit(maskable_interrupt_request, 1'b1, "mreq");
    chk_int(n_nmi, 1, "nmi");
    lint_req = 2'h0;
    step(6);
    chk_bit(maskable_interrupt_request, 1'b0, "mreq low");
    lapic_disable = 1'b0;
    repeat (20)
    begin
      fp_error = 1'($urandom);
      step(1);
    end
    fp_error = 1'b0;
    step(1);
    stop_clock_in_n = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      fp_error = (i > 0 && i < 15) ? 1'($urandom) : 1'b0;
      break_event = (i == 6);
      step(1);
    end
    stop_clock_in_n = 1'b1;
    step(3);
    n_fpx = 0;
    fp_error = 1'b1;
    step(1);
    fp_error = 1'b0;
    ign_req = 1'b1;
    step(6);
    issue();
    chk_int(n_fpx, 0, "ignored");
    ign_req = 1'b0;
    step(6);
    issue();
    chk_int(n_fpx, 1, "raised");
    issue();
    chk_int(n_fpx, 1, "cleared");
    native_numeric_error_bit = 1'b1;
    ign_req = 1'b1;
    fp_error = 1'b1;
    step(1);
    fp_error = 1'b0;
    step(6);
    issue();
    chk_int(n_fpx, 2, "native");
    native_numeric_error_bit = 1'b0;
    ign_req = 1'b0;
    repeat (4)
    begin
      snoop_stall_req = 1'b1;
      step($urandom_range(6, 1));
      snoop_stall_req = 1'b0;
      step($urandom_range(3, 1));
    end
    prio_req = 1'b1;
    lock_seq_start = 1'b1;
    step(1);
    lock_seq_start = 1'b0;
    step($urandom_range(9, 3));
    chk_bit(prio_owns_bus, 1'b0, "prio held off");
    lock_seq_end = 1'b1;
    step(1);
    lock_seq_end = 1'b0;
    lock_seq_start = 1'b1;
    step(1);
    lock_seq_start = 1'b0;
    step(3);
    chk_bit(prio_owns_bus, 1'b1, "prio owns");
    prio_req = 1'b0;
    lock_seq_start = 1'b1;
    step(1);
    lock_seq_start = 1'b0;
    lock_seq_end = 1'b1;
    step(1);
    lock_seq_end = 1'b0;
    internal_fault = 1'b1;
    step(1);
    internal_fault = 1'b0;
    step($urandom_range(12, 4));
    n_irr = 0;
    n_frv = 0;
    init_req = 1'b1;
    step(6);
    chk_int(lat, 3, "init sync");
    chk_int(n_irr, 1, "int reset");
    chk_int(n_frv, 1, "vector");
    rst_n = 1'b0;
    step(2);
    rst_n = 1'b1;
    step(3);
    chk_bit(bist_request, 1'b1, "bist");
    init_req = 1'b0;
    step(4);
    chk_bit(bist_request, 1'b1, "bist holds");
    chk_int(n_irr, 1, "strap not init");
    tally_and_finish();
  end

  // The sequence needs under two hundred cycles, so this limit only trips on a hang.
  initial
  begin
    #(2000 * 50);
    n_fail++;
    tally_and_finish();
  end
endmodule : tb_top
